// *** design/avc_params.svh ***
// constants for the adapter utility and control register block
`ifndef AVC_PARAMS_SVH
`define AVC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define AVC_OFS_DIAG_ONE 8'h1c
`define AVC_OFS_UTILITY 8'h20
`define AVC_OFS_CONTROL 8'h24

// ----------------------------------------------------------------------
// utility register fields
// ----------------------------------------------------------------------
`define AVC_UT_RETRY_HI 31
`define AVC_UT_RETRY_LO 28
`define AVC_UT_HOLD_HI 27
`define AVC_UT_HOLD_LO 24
`define AVC_UT_TMO_HI 23
`define AVC_UT_TMO_LO 20
`define AVC_UT_MODE_HI 19
`define AVC_UT_MODE_LO 18
`define AVC_UT_NARROW 17
`define AVC_UT_RSVD_HI 16
`define AVC_UT_RSVD_LO 14
`define AVC_UT_WIN_HI 13
`define AVC_UT_WIN_LO 0

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define AVC_CS_RSVD31 31
`define AVC_CS_PARTIAL_NODE_RESET 30
`define AVC_CS_SHORT_TMO 9
`define AVC_CS_RELOCATE 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define AVC_RST_RETRY 4'h4
`define AVC_RST_HOLD 4'h3
`define AVC_RST_TMO 4'hf
`define AVC_RST_MODE 2'h0
`define AVC_RST_WIN 14'h0000

// ----------------------------------------------------------------------
// window decode and address masking
// ----------------------------------------------------------------------
`define AVC_WIN_ORIGIN 32'he0000000
`define AVC_WIN_NODE_SHIFT 25
`define AVC_WIN_VME_SHIFT 13
`define AVC_NARROW_BITS 5

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define AVC_CLK_MHZ 40
`define AVC_TICK_NORMAL_US 1000
`define AVC_TICK_SHORT_US 64
`define AVC_TICK_NORMAL_CYC (`AVC_TICK_NORMAL_US * `AVC_CLK_MHZ)
`define AVC_TICK_SHORT_CYC (`AVC_TICK_SHORT_US * `AVC_CLK_MHZ)

`endif

// *** design/avc_pkg.sv ***
// types shared by the adapter utility and control block
`default_nettype none
package avc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } avc_reg_req_t;

  typedef enum logic [1:0] {
    AVC_MODE_NONE = 2'h0,
    AVC_MODE_512 = 2'h1,
    AVC_MODE_4K = 2'h2,
    AVC_MODE_8K = 2'h3
  } avc_mode_t;

  typedef enum logic [2:0] {
    AVC_TX_IDLE = 3'b001,
    AVC_TX_TIMING = 3'b010,
    AVC_TX_EXPIRED = 3'b100
  } avc_tx_state_t;
endpackage
`default_nettype wire

// *** design/avc_top.sv ***
// adapter utility/control registers with lockout, timeout and window decode
//
// Notes on behaviour
// - count failed interlocked reads; assert lockout once the retry limit is used up
// - retry limit resets to 4; codes 0 and 1 mean one attempt
// - lockout hold code n releases lockout within n-1 to n ms; reset 3
// - abort and flag timeout when retry or read wait outlasts the timeout code
// - timeout n gives n-1..n ms or (n-1)*64..n*64 us; scale bit chooses
// - timeout code resets to F, 14 to 15 ms
// - two-bit translation mode select, reset to no translation
// - narrow enable zeroes upper 5 address bits only in 512-byte mode
// - utility bits 16:14 read as zero
// - 14-bit window base field, resets to zero
// - unrelocated window base uses system node id and vme node id
// - relocated window base uses window base field instead of node id
// - relocated with zero base: refuse non-control-register vme io commands
// - control bit 30 write-only: writing one starts partial reset, reads zero
// - control reset acts even while the logic is hung or busy
// - control reset reinits logic, page maps, vme side, implied-vector enable
// - control reset leaves system bus register access untouched
// - control bit 31 reads as zero
// - short timeout select resets to zero, gives 0..960 us range
`include "avc_params.svh"
`default_nettype none
module avc_top
  import avc_pkg::*;
#(
  parameter int TICK_NORMAL_CYC = `AVC_TICK_NORMAL_CYC,
  parameter int TICK_SHORT_CYC = `AVC_TICK_SHORT_CYC,
  parameter int VME_ID_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic node_reset,
  input wire avc_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic interlocked_read_fail,
  input wire logic interlocked_read_done,
  output logic lockout,
  input wire logic txn_active,
  output logic txn_abort,
  output logic transaction_timeout_flag,
  input wire logic timeout_flag_clear,
  input wire logic [39:0] xlate_addr,
  output logic [39:0] dma_addr,
  output logic [1:0] translation_mode_select,
  input wire logic [3:0] sys_node_id,
  input wire logic [VME_ID_W-1:0] vme_node_id,
  output logic [31:0] window_base,
  input wire logic io_cmd_valid,
  input wire logic io_cmd_is_csr,
  output logic io_nack,
  output logic io_ack,
  output logic partial_node_reset,
  output logic vme_reset,
  output logic page_map_reset,
  output logic implied_vector_interrupt_disable
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [3:0] read_retry_limit_r;
  logic [3:0] lockout_hold_limit_r;
  logic [3:0] transaction_timeout_code_r;
  avc_mode_t translation_mode_r;
  logic narrow_address_enable_r;
  logic [13:0] window_base_field_r;
  logic short_timeout_select_r;
  logic window_relocate_enable_r;
  logic partial_node_reset_r;
  logic reg_rst;
  logic wr_util;
  logic wr_ctl;

  assign reg_rst = reset | node_reset;
  assign wr_util = reg_req.wr && (reg_req.addr == `AVC_OFS_UTILITY);
  assign wr_ctl = reg_req.wr && (reg_req.addr == `AVC_OFS_CONTROL);

  // registers are I/O registers: untouched by the control reset
  always_ff @(posedge clk) begin
    if (reg_rst) begin
      read_retry_limit_r <= `AVC_RST_RETRY;
      lockout_hold_limit_r <= `AVC_RST_HOLD;
      transaction_timeout_code_r <= `AVC_RST_TMO;
      translation_mode_r <= AVC_MODE_NONE;
      narrow_address_enable_r <= 1'b0;
      window_base_field_r <= `AVC_RST_WIN;
    end else if (wr_util) begin
      read_retry_limit_r <= reg_req.wdata[`AVC_UT_RETRY_HI:`AVC_UT_RETRY_LO];
      lockout_hold_limit_r <= reg_req.wdata[`AVC_UT_HOLD_HI:`AVC_UT_HOLD_LO];
      transaction_timeout_code_r <= reg_req.wdata[`AVC_UT_TMO_HI:`AVC_UT_TMO_LO];
      translation_mode_r <= avc_mode_t'(reg_req.wdata[`AVC_UT_MODE_HI:`AVC_UT_MODE_LO]);
      narrow_address_enable_r <= reg_req.wdata[`AVC_UT_NARROW];
      window_base_field_r <= reg_req.wdata[`AVC_UT_WIN_HI:`AVC_UT_WIN_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (reg_rst) begin
      short_timeout_select_r <= 1'b0;
      window_relocate_enable_r <= 1'b0;
    end else if (wr_ctl) begin
      short_timeout_select_r <= reg_req.wdata[`AVC_CS_SHORT_TMO];
      window_relocate_enable_r <= reg_req.wdata[`AVC_CS_RELOCATE];
    end
  end

  // control bit 30 is a strobe only, never stored as state
  always_ff @(posedge clk) begin
    if (reg_rst) begin
      partial_node_reset_r <= 1'b0;
    end else begin
      partial_node_reset_r <= wr_ctl && reg_req.wdata[`AVC_CS_PARTIAL_NODE_RESET];
    end
  end

  // read path stays live through a control reset
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      reg_rdata <= 32'h0;
      if (reg_req.rd) begin
        case (reg_req.addr)
          `AVC_OFS_UTILITY: begin
            reg_rdata <= {read_retry_limit_r, lockout_hold_limit_r,
                          transaction_timeout_code_r, translation_mode_r,
                          narrow_address_enable_r, 3'h0, window_base_field_r};
          end
          `AVC_OFS_CONTROL: begin
            reg_rdata <= {2'h0, 20'h0, short_timeout_select_r, 3'h0,
                          window_relocate_enable_r, 5'h0};
          end
          default: begin
            reg_rdata <= 32'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // control reset fan-out
  // ----------------------------------------------------------------------
  logic logic_rst;
  assign logic_rst = reg_rst | partial_node_reset_r;

  always_ff @(posedge clk) begin
    if (reg_rst) begin
      partial_node_reset <= 1'b0;
      vme_reset <= 1'b0;
      page_map_reset <= 1'b0;
      implied_vector_interrupt_disable <= 1'b0;
    end else begin
      partial_node_reset <= partial_node_reset_r;
      vme_reset <= partial_node_reset_r;
      page_map_reset <= partial_node_reset_r;
      implied_vector_interrupt_disable <= partial_node_reset_r;
    end
  end

  // ----------------------------------------------------------------------
  // prescaled ticks
  // ----------------------------------------------------------------------
  logic [15:0] ms_pre_r;
  logic [15:0] to_pre_r;
  logic ms_tick;
  logic to_tick;
  logic [15:0] to_period;
  logic scale_q;

  assign to_period = short_timeout_select_r ? 16'(TICK_SHORT_CYC - 1) : 16'(TICK_NORMAL_CYC - 1);
  assign ms_tick = (ms_pre_r == 16'(TICK_NORMAL_CYC - 1));
  assign to_tick = (to_pre_r == to_period);

  always_ff @(posedge clk) begin
    if (logic_rst || ms_tick) begin
      ms_pre_r <= 16'h0;
    end else begin
      ms_pre_r <= ms_pre_r + 16'h1;
    end
  end

  // a scale change restarts the timeout prescaler
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      to_pre_r <= 16'h0;
      scale_q <= 1'b0;
    end else begin
      scale_q <= short_timeout_select_r;
      if (to_tick || (scale_q != short_timeout_select_r)) begin
        to_pre_r <= 16'h0;
      end else begin
        to_pre_r <= to_pre_r + 16'h1;
      end
    end
  end

  function automatic logic [3:0] avc_eff(input logic [3:0] code);
    avc_eff = (code == 4'h0) ? 4'h1 : code;
  endfunction

  // ----------------------------------------------------------------------
  // interlocked read retry and lockout hold
  // ----------------------------------------------------------------------
  logic [3:0] retry_cnt_r;
  logic [3:0] hold_cnt_r;
  logic retry_exhausted;
  logic hold_expired;

  assign retry_exhausted = (retry_cnt_r + 4'h1) >= avc_eff(read_retry_limit_r);
  assign hold_expired = ms_tick && ((hold_cnt_r + 4'h1) >= avc_eff(lockout_hold_limit_r));

  always_ff @(posedge clk) begin
    if (logic_rst || interlocked_read_done) begin
      retry_cnt_r <= 4'h0;
    end else if (interlocked_read_fail && !lockout) begin
      retry_cnt_r <= retry_exhausted ? 4'h0 : retry_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (logic_rst || interlocked_read_done) begin
      lockout <= 1'b0;
      hold_cnt_r <= 4'h0;
    end else if (!lockout) begin
      hold_cnt_r <= 4'h0;
      lockout <= interlocked_read_fail && retry_exhausted;
    end else if (hold_expired) begin
      lockout <= 1'b0;
      hold_cnt_r <= 4'h0;
    end else if (ms_tick) begin
      hold_cnt_r <= hold_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // transaction timeout
  // ----------------------------------------------------------------------
  avc_tx_state_t tx_state_r;
  avc_tx_state_t tx_state_nxt;
  logic [3:0] to_cnt_r;
  logic to_expire;

  // the first tick lands anywhere in its period: expiry falls in n-1..n
  assign to_expire = to_tick && ((to_cnt_r + 4'h1) >= avc_eff(transaction_timeout_code_r));

  always_comb begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      AVC_TX_IDLE: begin
        if (txn_active) begin
          tx_state_nxt = AVC_TX_TIMING;
        end
      end
      AVC_TX_TIMING: begin
        if (!txn_active) begin
          tx_state_nxt = AVC_TX_IDLE;
        end else if (to_expire) begin
          tx_state_nxt = AVC_TX_EXPIRED;
        end
      end
      AVC_TX_EXPIRED: begin
        if (!txn_active) begin
          tx_state_nxt = AVC_TX_IDLE;
        end
      end
      default: begin
        tx_state_nxt = AVC_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (logic_rst) begin
      tx_state_r <= AVC_TX_IDLE;
    end else begin
      tx_state_r <= tx_state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (logic_rst || tx_state_r != AVC_TX_TIMING) begin
      to_cnt_r <= 4'h0;
    end else if (to_tick) begin
      to_cnt_r <= to_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (logic_rst) begin
      txn_abort <= 1'b0;
    end else begin
      txn_abort <= (tx_state_r == AVC_TX_TIMING) && txn_active && to_expire;
    end
  end

  // new timeout wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      transaction_timeout_flag <= 1'b0;
    end else if (txn_abort) begin
      transaction_timeout_flag <= 1'b1;
    end else if (timeout_flag_clear) begin
      transaction_timeout_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // dma address masking and mode out
  // ----------------------------------------------------------------------
  logic narrow_active;
  assign narrow_active = narrow_address_enable_r && (translation_mode_r == AVC_MODE_512);

  always_ff @(posedge clk) begin
    if (logic_rst) begin
      dma_addr <= 40'h0;
      translation_mode_select <= 2'h0;
    end else begin
      translation_mode_select <= translation_mode_r;
      dma_addr <= narrow_active ? {`AVC_NARROW_BITS'(0), xlate_addr[34:0]} : xlate_addr;
    end
  end

  // ----------------------------------------------------------------------
  // window decode and io command refusal
  // ----------------------------------------------------------------------
  logic [31:0] win_sel;
  logic [31:0] win_vme;
  logic refuse;

  // software must program a nonzero base before relocating
  assign win_sel = window_relocate_enable_r ? 32'(window_base_field_r) : 32'(sys_node_id);
  assign win_vme = 32'(vme_node_id);
  assign refuse = window_relocate_enable_r && (window_base_field_r == 14'h0) && !io_cmd_is_csr;

  always_ff @(posedge clk) begin
    if (logic_rst) begin
      window_base <= `AVC_WIN_ORIGIN;
      io_nack <= 1'b0;
      io_ack <= 1'b0;
    end else begin
      window_base <= 32'(`AVC_WIN_ORIGIN + (win_sel << `AVC_WIN_NODE_SHIFT)
                     + (win_vme << `AVC_WIN_VME_SHIFT));
      io_nack <= io_cmd_valid && refuse;
      io_ack <= io_cmd_valid && !refuse;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [7:0] rd_addr_q;
  always_ff @(posedge clk) begin
    rd_addr_q <= reg_req.addr;
  end

  property p_util_rsvd_zero;
    @(posedge clk) disable iff (reset)
      reg_rvalid && rd_addr_q == `AVC_OFS_UTILITY |-> reg_rdata[16:14] == 3'h0;
  endproperty
  a_util_rsvd_zero: assert property (p_util_rsvd_zero) else $error("utility reserved bits set");

  property p_ctl_top_zero;
    @(posedge clk) disable iff (reset)
      reg_rvalid && rd_addr_q == `AVC_OFS_CONTROL |-> reg_rdata[31:30] == 2'h0;
  endproperty
  a_ctl_top_zero: assert property (p_ctl_top_zero) else $error("control bits 31:30 read nonzero");

  property p_reset_values;
    @(posedge clk) $past(reg_rst) |-> read_retry_limit_r == 4'h4
      && lockout_hold_limit_r == 4'h3 && transaction_timeout_code_r == 4'hf
      && translation_mode_r == AVC_MODE_NONE && !short_timeout_select_r;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("wrong reset values");

  property p_lockout_at_limit;
    @(posedge clk) disable iff (logic_rst)
      interlocked_read_fail && !lockout && !interlocked_read_done && retry_exhausted |=> lockout;
  endproperty
  a_lockout_at_limit: assert property (p_lockout_at_limit) else $error("no lockout at limit");

  property p_abort_flags;
    @(posedge clk) disable iff (logic_rst) txn_abort |=> transaction_timeout_flag;
  endproperty
  a_abort_flags: assert property (p_abort_flags) else $error("timeout abort without flag");

  property p_narrow_mask;
    @(posedge clk) disable iff (logic_rst)
      narrow_active && $stable(narrow_active) |=> dma_addr[39:35] == 5'h0
      && dma_addr[34:0] == $past(xlate_addr[34:0]);
  endproperty
  a_narrow_mask: assert property (p_narrow_mask) else $error("narrow address not masked");

  property p_refuse_zero_base;
    @(posedge clk) disable iff (logic_rst)
      io_cmd_valid && !io_cmd_is_csr && window_relocate_enable_r && window_base_field_r == 14'h0
      |=> io_nack && !io_ack;
  endproperty
  a_refuse_zero_base: assert property (p_refuse_zero_base) else $error("io command not refused");

  property p_partial_node_reset_fanout;
    @(posedge clk) disable iff (reg_rst)
      wr_ctl && reg_req.wdata[30] |=> ##1 vme_reset && page_map_reset && !lockout
      && tx_state_r == AVC_TX_IDLE;
  endproperty
  a_partial_node_reset_fanout: assert property (p_partial_node_reset_fanout) else $error("control reset missed");

  // short-scale wait, restarted on entry, scale change or any utility rewrite
  logic [15:0] short_age_r;
  logic short_live;
  assign short_live = (tx_state_r == AVC_TX_TIMING) && txn_active && short_timeout_select_r;

  always_ff @(posedge clk) begin
    if (logic_rst || !short_live || wr_util) begin
      short_age_r <= 16'h0;
    end else if (short_age_r != 16'hffff) begin
      short_age_r <= short_age_r + 16'h1;
    end
  end

  property p_short_bound;
    @(posedge clk) disable iff (logic_rst)
      short_live |-> int'(short_age_r)
      <= int'(avc_eff(transaction_timeout_code_r)) * TICK_SHORT_CYC + 2;
  endproperty
  a_short_bound: assert property (p_short_bound) else $error("short timeout too slow");

endmodule
`default_nettype wire

// *** tb/avc_host_model.sv ***
// host bus model issuing register cycles toward the block
`default_nettype none
module avc_host_model
  import avc_pkg::*;
(
  input wire logic clk,
  output avc_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;
  initial reg_req = '0;

  // released lines show the inverse, so a stale copy is never mistaken for data
  task automatic release_bus();
    reg_req <= '{addr: ~reg_req.addr, wr: 1'b0, rd: 1'b0, wdata: ~reg_req.wdata};
  endtask

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    release_bus();
    #1;
    repeat (gap) @(posedge clk);
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: reg_req.wdata};
    @(posedge clk);
    release_bus();
    #1;
    d = reg_rvalid ? reg_rdata : 32'hxxxxxxxx;
    repeat (gap) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb/avc_top_tb.sv ***
// self-checking bench for the adapter utility and control block
`default_nettype none
module avc_top_tb
  import avc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TN = 40;
  localparam int TS = 8;
  logic clk, reset, node_reset, interlocked_read_fail, interlocked_read_done, txn_active, timeout_flag_clear;
  logic io_cmd_valid, io_cmd_is_csr, reg_rvalid, lockout, txn_abort, tmo_flag, io_nack, io_ack;
  logic pnr, vrst, page_map_register, ivd, seen_clr;
  logic [39:0] xlate_addr, dma_addr;
  logic [31:0] reg_rdata, window_base, rd, v, seed;
  logic [1:0] mode;
  logic [3:0] sys_node_id, seen_rst;
  logic [7:0] vme_node_id;
  logic [13:0] base;
  avc_reg_req_t reg_req;
  int n_fail = 0, n_tests = 0, cyc = 0, c, m, k, t;
  int lim_codes[4] = '{0, 1, 2, 5};
  int tmo_codes[5] = '{1, 3, 0, 2, 15};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  avc_top #(.TICK_NORMAL_CYC(TN), .TICK_SHORT_CYC(TS)) dut_u (
    .clk(clk), .reset(reset), .node_reset(node_reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .interlocked_read_fail(interlocked_read_fail),
    .interlocked_read_done(interlocked_read_done), .lockout(lockout), .txn_active(txn_active),
    .txn_abort(txn_abort), .transaction_timeout_flag(tmo_flag),
    .timeout_flag_clear(timeout_flag_clear), .xlate_addr(xlate_addr), .dma_addr(dma_addr),
    .translation_mode_select(mode), .sys_node_id(sys_node_id), .vme_node_id(vme_node_id),
    .window_base(window_base), .io_cmd_valid(io_cmd_valid), .io_cmd_is_csr(io_cmd_is_csr),
    .io_nack(io_nack), .io_ack(io_ack), .partial_node_reset(pnr), .vme_reset(vrst),
    .page_map_reset(page_map_register), .implied_vector_interrupt_disable(ivd));

  avc_host_model host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  always @(posedge clk) seen_rst <= seen_clr ? 4'h0 : (seen_rst | {pnr, vrst, page_map_register, ivd});

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    host_u.read(a, rd);
    chk(nm, {8'h0, rd}, {8'h0, e});
  endtask

  task automatic wait_for(ref logic s, input logic lv, input int lim, output int n);
    n = 0;
    while (s !== lv && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  function automatic logic [31:0] wexp(input logic [13:0] node, input logic [7:0] vid);
    return 32'he0000000 + ({18'h0, node} << 25) + ({24'h0, vid} << 13);
  endfunction

  task automatic fail_pulse();
    @(posedge clk) interlocked_read_fail <= 1'b1;
    @(posedge clk) interlocked_read_fail <= 1'b0;
  endtask

  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'hca84;
    {reset, node_reset, interlocked_read_fail, interlocked_read_done, txn_active} = 5'b10000;
    {timeout_flag_clear, io_cmd_valid, io_cmd_is_csr, seen_clr} = 4'h1;
    {xlate_addr, sys_node_id, vme_node_id} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    seen_clr <= 1'b0;
    rchk("utility", 8'h20, 32'h43f00000);
    rchk("control", 8'h24, 32'h0);
    rchk("diag", 8'h1c, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      host_u.gap = i % 2;
      v = $random(seed);
      host_u.write(8'h20, v);
      rchk("utility rw", 8'h20, v & 32'hfffe3fff);
    end
    host_u.gap = 0;
    @(posedge clk) node_reset <= 1'b1;
    @(posedge clk) node_reset <= 1'b0;
    rchk("node reset", 8'h20, 32'h43f00000);
    $display("test register access done");
    foreach (lim_codes[i]) begin
      c = lim_codes[i];
      m = (c < 2) ? 1 : c;
      host_u.write(8'h20, {c[3:0], 28'hff00000});
      for (int j = 1; j <= m; j++) begin
        fail_pulse();
        repeat (2) @(posedge clk);
        #1;
        chk("lockout", lockout, j == m);
      end
      @(posedge clk) interlocked_read_done <= 1'b1;
      @(posedge clk) interlocked_read_done <= 1'b0;
    end
    $display("test retry limit done");
    for (int h = 0; h < 4; h += 2) begin
      m = (h < 2) ? 1 : h;
      host_u.write(8'h20, {4'h1, h[3:0], 24'hf00000});
      fail_pulse();
      wait_for(lockout, 1'b1, 8, k);
      chk("hold set", lockout, 1);
      wait_for(lockout, 1'b0, 700, k);
      chk("hold", k >= (m - 1) * TN && k <= m * TN + 2, 1);
    end
    $display("test lockout hold done");
    foreach (tmo_codes[i]) begin
      c = tmo_codes[i];
      m = (c < 2) ? 1 : c;
      t = (i >= 2) ? TS : TN;
      host_u.write(8'h24, {22'h0, i >= 2, 9'h0});
      host_u.write(8'h20, {8'h43, c[3:0], 20'h0});
      @(posedge clk) txn_active <= 1'b1;
      wait_for(txn_abort, 1'b1, 700, k);
      chk("abort time", k >= (m - 1) * t && k <= m * t + 3, 1);
      @(posedge clk) txn_active <= 1'b0;
      #1;
      chk("flag", tmo_flag, 1);
      @(posedge clk) timeout_flag_clear <= 1'b1;
      @(posedge clk) timeout_flag_clear <= 1'b0;
      #1;
      chk("flag clear", tmo_flag, 0);
    end
    $display("test timeout done");
    host_u.write(8'h20, 32'h1ff00000);
    fail_pulse();
    wait_for(lockout, 1'b1, 8, k);
    chk("lockout set", lockout, 1);
    txn_active <= 1'b1;
    seen_clr <= 1'b1;
    @(posedge clk) seen_clr <= 1'b0;
    host_u.write(8'h24, 32'hc0000220);
    repeat (4) @(posedge clk);
    #1;
    chk("reset fanout", seen_rst, 4'hf);
    chk("lockout cleared", lockout, 0);
    txn_active <= 1'b0;
    rchk("control rb", 8'h24, 32'h220);
    rchk("utility kept", 8'h20, 32'h1ff00000);
    $display("test control reset done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) {io_cmd_valid, io_cmd_is_csr} <= {1'b1, s[0]};
      @(posedge clk) io_cmd_valid <= 1'b0;
      #1;
      chk("io reply", {io_nack, io_ack}, s ? 2'b01 : 2'b10);
    end
    host_u.write(8'h24, 32'h0);
    v = $random(seed);
    {sys_node_id, vme_node_id} <= v[11:0];
    base = v[29:16] | 14'h1;
    repeat (3) @(posedge clk);
    #1;
    chk("window fixed", window_base, wexp({10'h0, v[11:8]}, v[7:0]));
    host_u.write(8'h20, {18'h10fc0, base});
    host_u.write(8'h24, 32'h20);
    {io_cmd_valid, io_cmd_is_csr} <= 2'b10;
    @(posedge clk) io_cmd_valid <= 1'b0;
    #1;
    chk("io relocated", {io_nack, io_ack}, 2'b01);
    chk("window moved", window_base, wexp(base, v[7:0]));
    $display("test window done");
    for (int md = 0; md < 4; md++) begin
      host_u.write(8'h20, {12'h43f, md[1:0], 18'h20000});
      v = $random(seed);
      xlate_addr <= {v[7:0], $random(seed)};
      repeat (2) @(posedge clk);
      #1;
      chk("mode", mode, md);
      chk("dma addr", dma_addr, md == 1 ? {5'h0, xlate_addr[34:0]} : xlate_addr);
    end
    $display("test translation done");
    finish_test();
  end
endmodule
`default_nettype wire
